// ===== src/tmc_pkg.sv
/*
 Constants, register indexes and state carriers for the 16-bit timer counter
 with input capture. Assumes one 10 MHz system clock and an 8-bit host bus.
*/
// What this block does
// RULE1: One shared holding register serves every high byte
// RULE2: Low byte read/write moves high byte atomically
// RULE3: Sixteen-bit up/down counter, top and bottom flags
// RULE4: Each tick clears, increments or decrements per mode
// RULE5: Clock select zero stops the counter
// RULE6: Counter readable and writable while stopped or running
// RULE7: Host counter write beats a simultaneous count
// RULE8: Overflow flag set per mode, raises request
// RULE9: Qualified capture edge copies full count
// RULE10: Capture flag set with the capture copy
// RULE11: Enabled capture flag raises a capture request
// RULE12: Capture flag clears on service or written one
// RULE13: Capture low byte read fills holding register
// RULE14: Capture register writable only as top value
// RULE15: Host writes capture high byte before low
// RULE16: Trigger from pin, or comparator when selected
// RULE17: Host clears capture flag after source change
// RULE18: Sources synchronized; filter adds four cycles delay
// RULE19: Capture input disabled in capture-top modes
// RULE20: Pin level captures whatever drives the pin
// RULE21: Host masks interrupts around two-byte accesses; the bench runs wr16 and rd16 with requests left enabled
// RULE22: Host may reuse one high byte for many
// RULE23: Filter output changes after four agreeing samples
// RULE24: Filter enable in control B, system clock
// RULE25: Compare registers read directly, no holding register
// RULE26: Edge select chooses rising or falling capture
package tmc_pkg;
    localparam logic [3:0] REG_CTRL_A = 4'h0;
    localparam logic [3:0] REG_CTRL_B = 4'h1;
    localparam logic [3:0] REG_CNT_LO = 4'h2;
    localparam logic [3:0] REG_CNT_HI = 4'h3;
    localparam logic [3:0] REG_CAP_LO = 4'h4;
    localparam logic [3:0] REG_CAP_HI = 4'h5;
    localparam logic [3:0] REG_CMPA_LO = 4'h6;
    localparam logic [3:0] REG_CMPA_HI = 4'h7;
    localparam logic [3:0] REG_CMPB_LO = 4'h8;
    localparam logic [3:0] REG_CMPB_HI = 4'h9;
    localparam logic [3:0] REG_FLAGS = 4'ha;
    localparam logic [3:0] REG_MASK = 4'hb;
    localparam int B_FILTER_EN = 7;
    localparam int B_EDGE_RISE = 6;
    localparam int F_OVF = 0;
    localparam int F_CAP = 1;
    localparam logic [15:0] TOP_MAX = 16'hffff;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    localparam logic [9:0] PRE_MASK_8 = 10'h007;
    localparam logic [9:0] PRE_MASK_64 = 10'h03f;
    localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
    localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;
    localparam logic [3:0] FILTER_ALL_ONE = 4'hf;
    localparam logic [3:0] FILTER_ALL_ZERO = 4'h0;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } tmc_bus_req_t;

    typedef struct packed {
        logic [2:0] sync;
        logic [3:0] hist;
        logic       level;
        logic       rise;
        logic       fall;
    } tmc_cond_t;

    typedef struct packed {
        logic [9:0] pre;
        logic       tick;
    } tmc_tick_t;

    typedef struct packed {
        logic [7:0]  temp;
        logic [15:0] count;
        logic [15:0] capture;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [1:0]  ctrl_a;
        logic [7:0]  ctrl_b;
        logic        down;
        logic        ovf_flag;
        logic        cap_flag;
        logic        ovf_ie;
        logic        cap_ie;
        logic [7:0]  rdata;
        logic        at_top;
        logic        at_bottom;
        logic        ovf_irq;
        logic        cap_irq;
    } tmc_core_t;
endpackage

// ===== src/tmc_pin_cond.sv
/*
 Pin conditioner: three-stage synchronizer, optional four-sample filter and
 edge detector. Assumes pin is asynchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module tmc_pin_cond (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic pin,
    input  wire logic filter_en,
    output logic      rise,
    output logic      fall
);
    tmc_pkg::tmc_cond_t st;
    tmc_pkg::tmc_cond_t next_st;
    logic               cand;
    logic               new_level;

    always_comb
    begin
        next_st = st;
        next_st.sync = {st.sync[1:0], pin};
        // Accept a change once the second and third stages agree
        cand = (st.sync[2] == st.sync[1]) ? st.sync[2] : st.hist[0]; // RULE18 RULE20
        next_st.hist = {st.hist[2:0], cand};
        new_level = st.level;
        if (!filter_en)
            new_level = cand;
        // Four stored samples must agree, which costs four cycles of delay
        else if (st.hist == tmc_pkg::FILTER_ALL_ONE || st.hist == tmc_pkg::FILTER_ALL_ZERO)
            new_level = st.hist[0]; // RULE23 RULE24
        next_st.level = new_level;
        next_st.rise = new_level & ~st.level;
        next_st.fall = ~new_level & st.level;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign rise = st.rise;
    assign fall = st.fall;
endmodule
`default_nettype wire

// ===== src/tmc_tick_gen.sv
/*
 Timer tick source: prescaled system clock or external pin edges, chosen
 by the clock select bits. Assumes edge inputs are one-cycle pulses.
*/
`timescale 1ns/100ps
`default_nettype none
module tmc_tick_gen (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [2:0] clock_select_bits,
    input  wire logic       ext_rise,
    input  wire logic       ext_fall,
    output logic            timer_tick
);
    tmc_pkg::tmc_tick_t st;
    tmc_pkg::tmc_tick_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.pre = (clock_select_bits == 3'h0) ? 10'h000 : st.pre + 10'h001;
        unique case (clock_select_bits)
            3'h0: next_st.tick = 1'b0; // RULE5
            3'h1: next_st.tick = 1'b1;
            3'h2: next_st.tick = (st.pre & tmc_pkg::PRE_MASK_8) == tmc_pkg::PRE_MASK_8;
            3'h3: next_st.tick = (st.pre & tmc_pkg::PRE_MASK_64) == tmc_pkg::PRE_MASK_64;
            3'h4: next_st.tick = (st.pre & tmc_pkg::PRE_MASK_256) == tmc_pkg::PRE_MASK_256;
            3'h5: next_st.tick = st.pre == tmc_pkg::PRE_MASK_1024;
            3'h6: next_st.tick = ext_fall;
            3'h7: next_st.tick = ext_rise;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign timer_tick = st.tick;
endmodule
`default_nettype wire

// ===== src/tmc_timer16.sv
/*
 Sixteen-bit timer counter with input capture, reached over an 8-bit host
 bus with one shared high-byte holding register. Assumes a single-cycle bus
 strobe from a core on clk, pins asynchronous, comparator select from the
 comparator block on clk.
*/
`timescale 1ns/100ps
`default_nettype none
module tmc_timer16 (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire tmc_pkg::tmc_bus_req_t bus_req,
    output logic [7:0]                 bus_rdata,
    input  wire logic                  capture_pin,
    input  wire logic                  comparator_output,
    input  wire logic                  comparator_capture_select,
    input  wire logic                  external_count_pin,
    input  wire logic                  ovf_irq_ack,
    input  wire logic                  cap_irq_ack,
    output logic                       ovf_irq,
    output logic                       cap_irq,
    output logic                       count_at_top,
    output logic                       count_at_bottom
);
    tmc_pkg::tmc_core_t st;
    tmc_pkg::tmc_core_t next_st;
    logic               cap_src;
    logic               cap_rise;
    logic               cap_fall;
    logic               ext_rise;
    logic               ext_fall;
    logic               timer_tick;
    logic [3:0]         mode;
    logic [15:0]        top;
    logic               icr_top;
    logic               dual;
    logic               clear_at_top;
    logic               cap_edge;
    logic               rd;
    logic               wr;
    logic [3:0]         addr;
    logic [7:0]         wdata;

    function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] cmp_a,
                                           input logic [15:0] cap);
        unique case (m)
            4'h1, 4'h5: top_of = tmc_pkg::TOP_8BIT;
            4'h2, 4'h6: top_of = tmc_pkg::TOP_9BIT;
            4'h3, 4'h7: top_of = tmc_pkg::TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf: top_of = cmp_a;
            4'h8, 4'ha, 4'hc, 4'he: top_of = cap;
            default: top_of = tmc_pkg::TOP_MAX;
        endcase
    endfunction

    // Source mux ahead of the synchronizer; switching it may look like an edge
    assign cap_src = comparator_capture_select ? comparator_output : capture_pin; // RULE16

    tmc_pin_cond u_cap_cond (
        .clk       (clk),
        .arst_n    (arst_n),
        .pin       (cap_src),
        .filter_en (st.ctrl_b[tmc_pkg::B_FILTER_EN]),
        .rise      (cap_rise),
        .fall      (cap_fall)
    );

    tmc_pin_cond u_ext_cond (
        .clk       (clk),
        .arst_n    (arst_n),
        .pin       (external_count_pin),
        .filter_en (1'b0),
        .rise      (ext_rise),
        .fall      (ext_fall)
    );

    tmc_tick_gen u_tick (
        .clk               (clk),
        .arst_n            (arst_n),
        .clock_select_bits (st.ctrl_b[2:0]),
        .ext_rise          (ext_rise),
        .ext_fall          (ext_fall),
        .timer_tick        (timer_tick)
    );

    always_comb
    begin
        next_st = st;
        rd = bus_req.rd;
        wr = bus_req.wr;
        addr = bus_req.addr;
        wdata = bus_req.wdata;
        mode = {st.ctrl_b[4:3], st.ctrl_a};
        top = top_of(mode, st.cmp_a, st.capture);
        icr_top = (mode == 4'h8) || (mode == 4'ha) || (mode == 4'hc) || (mode == 4'he);
        dual = (mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
        clear_at_top = (mode inside {4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'he, 4'hf});
        cap_edge = (st.ctrl_b[tmc_pkg::B_EDGE_RISE] ? cap_rise : cap_fall) && !icr_top; // RULE26 RULE19

        // Counting sequence set by the waveform mode
        if (timer_tick)
        begin
            if (dual)
            begin
                if (!st.down)
                begin
                    if (st.count >= top)
                    begin
                        next_st.down = 1'b1;
                        next_st.count = st.count - 16'h0001; // RULE3 RULE4
                    end
                    else
                        next_st.count = st.count + 16'h0001;
                end
                else if (st.count == 16'h0000)
                begin
                    next_st.down = 1'b0;
                    next_st.count = 16'h0001;
                end
                else
                begin
                    next_st.count = st.count - 16'h0001;
                    if (st.count == 16'h0001)
                        next_st.ovf_flag = 1'b1; // RULE8
                end
            end
            else
            begin
                next_st.down = 1'b0;
                if (clear_at_top && st.count == top)
                    next_st.count = 16'h0000; // RULE4
                else
                    next_st.count = st.count + 16'h0001;
                if ((clear_at_top && mode != 4'h4 && mode != 4'hc) ? (st.count == top)
                                                                   : (st.count == tmc_pkg::TOP_MAX))
                    next_st.ovf_flag = 1'b1; // RULE8
            end
        end

        // Flag clears by service or by a written one
        if (ovf_irq_ack)
            next_st.ovf_flag = 1'b0;
        if (cap_irq_ack)
            next_st.cap_flag = 1'b0; // RULE12
        if (wr && addr == tmc_pkg::REG_FLAGS)
        begin
            if (wdata[tmc_pkg::F_OVF])
                next_st.ovf_flag = 1'b0;
            if (wdata[tmc_pkg::F_CAP])
                next_st.cap_flag = 1'b0; // RULE12
        end
        // A new event wins over a clear in the same cycle
        if (timer_tick && dual && st.down && st.count == 16'h0001)
            next_st.ovf_flag = 1'b1;
        if (timer_tick && !dual && ((clear_at_top && mode != 4'h4 && mode != 4'hc) ? (st.count == top)
                                                                   : (st.count == tmc_pkg::TOP_MAX)))
            next_st.ovf_flag = 1'b1;
        if (cap_edge)
        begin
            next_st.capture = st.count; // RULE9
            next_st.cap_flag = 1'b1; // RULE10
        end

        // Host reads; counter and capture low byte reads fill the holding register
        if (rd)
        begin
            unique case (addr)
                tmc_pkg::REG_CTRL_A: next_st.rdata = {6'h00, st.ctrl_a};
                tmc_pkg::REG_CTRL_B: next_st.rdata = {st.ctrl_b[7:6], 1'b0, st.ctrl_b[4:0]};
                tmc_pkg::REG_CNT_LO:
                begin
                    next_st.rdata = st.count[7:0]; // RULE6
                    next_st.temp = st.count[15:8]; // RULE2
                end
                tmc_pkg::REG_CAP_LO:
                begin
                    next_st.rdata = st.capture[7:0];
                    next_st.temp = st.capture[15:8]; // RULE13
                end
                tmc_pkg::REG_CNT_HI, tmc_pkg::REG_CAP_HI: next_st.rdata = st.temp; // RULE1 RULE13
                tmc_pkg::REG_CMPA_LO: next_st.rdata = st.cmp_a[7:0];
                tmc_pkg::REG_CMPA_HI: next_st.rdata = st.cmp_a[15:8]; // RULE25
                tmc_pkg::REG_CMPB_LO: next_st.rdata = st.cmp_b[7:0];
                tmc_pkg::REG_CMPB_HI: next_st.rdata = st.cmp_b[15:8]; // RULE25
                tmc_pkg::REG_FLAGS: next_st.rdata = {6'h00, st.cap_flag, st.ovf_flag};
                tmc_pkg::REG_MASK: next_st.rdata = {6'h00, st.cap_ie, st.ovf_ie};
                default: next_st.rdata = 8'h00;
            endcase
        end

        // Host writes; a counter write overrides the tick above
        if (wr)
        begin
            unique case (addr)
                tmc_pkg::REG_CTRL_A: next_st.ctrl_a = wdata[1:0];
                tmc_pkg::REG_CTRL_B: next_st.ctrl_b = {wdata[7:6], 1'b0, wdata[4:0]};
                tmc_pkg::REG_CNT_HI, tmc_pkg::REG_CAP_HI,
                tmc_pkg::REG_CMPA_HI, tmc_pkg::REG_CMPB_HI: next_st.temp = wdata; // RULE1
                tmc_pkg::REG_CNT_LO: next_st.count = {st.temp, wdata}; // RULE2 RULE7
                tmc_pkg::REG_CAP_LO:
                begin
                    if (icr_top)
                        next_st.capture = {st.temp, wdata}; // RULE14
                end
                tmc_pkg::REG_CMPA_LO: next_st.cmp_a = {st.temp, wdata};
                tmc_pkg::REG_CMPB_LO: next_st.cmp_b = {st.temp, wdata};
                tmc_pkg::REG_MASK:
                begin
                    next_st.ovf_ie = wdata[tmc_pkg::F_OVF];
                    next_st.cap_ie = wdata[tmc_pkg::F_CAP];
                end
                default: next_st.temp = next_st.temp;
            endcase
        end

        next_st.at_top = next_st.count == top_of({next_st.ctrl_b[4:3], next_st.ctrl_a},
                                                 next_st.cmp_a, next_st.capture); // RULE3
        next_st.at_bottom = next_st.count == 16'h0000;
        next_st.ovf_irq = next_st.ovf_flag & next_st.ovf_ie; // RULE8
        next_st.cap_irq = next_st.cap_flag & next_st.cap_ie; // RULE11
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st <= '0;
            st.at_bottom <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign bus_rdata = st.rdata;
    assign ovf_irq = st.ovf_irq;
    assign cap_irq = st.cap_irq;
    assign count_at_top = st.at_top;
    assign count_at_bottom = st.at_bottom;
endmodule
`default_nettype wire

// ===== bench/tmc_host.sv
/*
 Host core model: drives the 8-bit register bus and the service pulses.
 Assumes the strobes are sampled on the rising edge of clk.
*/
`timescale 1ns/100ps
`default_nettype none
module tmc_host (
    input  wire logic                  clk,
    input  wire logic [7:0]            bus_rdata,
    output var tmc_pkg::tmc_bus_req_t  bus_req,
    output logic                       ovf_irq_ack,
    output logic                       cap_irq_ack
);
    initial
    begin
        bus_req = '0;
        ovf_irq_ack = 1'b0;
        cap_irq_ack = 1'b0;
    end

    // One-cycle strobe, then one idle cycle; pairs are never interleaved
    task automatic acc(input logic r, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        bus_req = '{rd: r, wr: !r, addr: a, wdata: d};
        @(negedge clk);
        q = bus_rdata;
        bus_req = '0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b0, a, d, q);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        acc(1'b1, a, 8'h00, q);
    endtask

    task automatic wr16(input logic [3:0] a_hi, input logic [15:0] v);
        wr(a_hi, v[15:8]);
        wr(a_hi - 4'h1, v[7:0]);
    endtask

    task automatic rd16(input logic [3:0] a_lo, output logic [15:0] v);
        rd(a_lo, v[7:0]);
        rd(a_lo + 4'h1, v[15:8]);
    endtask

    task automatic ack(input logic cap);
        @(negedge clk);
        if (cap)
            cap_irq_ack = 1'b1;
        else
            ovf_irq_ack = 1'b1;
        @(negedge clk);
        cap_irq_ack = 1'b0;
        ovf_irq_ack = 1'b0;
    endtask

    task automatic clr_cap;
        wr(tmc_pkg::REG_FLAGS, 8'h02);
    endtask
endmodule
`default_nettype wire

// ===== bench/tmc_timer16_checker.sv
/*
 Port checker for the timer block.
 Assumes it is bound to every instance of the top module.
*/
`timescale 1ns/100ps
`default_nettype none
module tmc_timer16_checker (
    input wire logic                  clk,
    input wire logic                  arst_n,
    input wire tmc_pkg::tmc_bus_req_t bus_req,
    input wire logic [7:0]            bus_rdata,
    input wire logic                  ovf_irq_ack,
    input wire logic                  cap_irq_ack,
    input wire logic                  ovf_irq,
    input wire logic                  cap_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_hi_wr;
        bus_req.wr && (bus_req.addr == tmc_pkg::REG_CNT_HI || bus_req.addr == tmc_pkg::REG_CMPA_HI);
    endsequence
    sequence s_hi_rd;
        bus_req.rd && (bus_req.addr == tmc_pkg::REG_CNT_HI || bus_req.addr == tmc_pkg::REG_CAP_HI);
    endsequence

    property p_temp_shared;
        s_hi_wr ##1 (!bus_req.rd && !bus_req.wr) ##1 s_hi_rd |=> bus_rdata == $past(bus_req.wdata, 3);
    endproperty
    a_temp_shared: assert property (p_temp_shared) else $error("high byte read missed holding value");

    property p_rdata_hold;
        !$past(bus_req.rd) |-> $stable(bus_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

    property p_unmapped;
        bus_req.rd && bus_req.addr > tmc_pkg::REG_MASK |=> bus_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_cap_ack;
        cap_irq_ack |-> ##2 !cap_irq;
    endproperty
    a_cap_ack: assert property (p_cap_ack) else $error("capture request survived service");

    property p_ovf_ack;
        ovf_irq_ack |-> ##2 !ovf_irq;
    endproperty
    a_ovf_ack: assert property (p_ovf_ack) else $error("overflow request survived service");

    property p_cap_w1c;
        bus_req.wr && bus_req.addr == tmc_pkg::REG_FLAGS && bus_req.wdata[tmc_pkg::F_CAP] |-> ##2 !cap_irq;
    endproperty
    a_cap_w1c: assert property (p_cap_w1c) else $error("capture flag not cleared by one");

    property p_cap_mask;
        bus_req.wr && bus_req.addr == tmc_pkg::REG_MASK && !bus_req.wdata[1] |-> ##2 !cap_irq;
    endproperty
    a_cap_mask: assert property (p_cap_mask) else $error("capture request while disabled");

    property p_ovf_mask;
        bus_req.wr && bus_req.addr == tmc_pkg::REG_MASK && !bus_req.wdata[0] |-> ##2 !ovf_irq;
    endproperty
    a_ovf_mask: assert property (p_ovf_mask) else $error("overflow request while disabled");
endmodule

bind tmc_timer16 tmc_timer16_checker u_chk (
    .clk         (clk),
    .arst_n      (arst_n),
    .bus_req     (bus_req),
    .bus_rdata   (bus_rdata),
    .ovf_irq_ack (ovf_irq_ack),
    .cap_irq_ack (cap_irq_ack),
    .ovf_irq     (ovf_irq),
    .cap_irq     (cap_irq)
);
`default_nettype wire

// ===== bench/tb_timer16_counter_input_capture.sv
/*
 Self-checking bench for the timer block, driven through the host model.
 Assumes inputs change on the falling edge of a 10 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_timer16_counter_input_capture;
    logic                  clk;
    logic                  arst_n;
    tmc_pkg::tmc_bus_req_t bus_req;
    logic [7:0]            bus_rdata;
    logic                  capture_pin;
    logic                  comparator_output;
    logic                  comparator_capture_select;
    logic                  external_count_pin;
    logic                  ovf_irq_ack;
    logic                  cap_irq_ack;
    logic                  ovf_irq;
    logic                  cap_irq;
    logic                  count_at_top;
    logic                  count_at_bottom;
    int                    errors;
    int                    total_checks;
    int                    cyc;
    logic [7:0]            b;
    logic [15:0]           v;
    int                    n0;
    int                    n;

    tmc_timer16 u_dut (
        .clk                       (clk),
        .arst_n                    (arst_n),
        .bus_req                   (bus_req),
        .bus_rdata                 (bus_rdata),
        .capture_pin               (capture_pin),
        .comparator_output         (comparator_output),
        .comparator_capture_select (comparator_capture_select),
        .external_count_pin        (external_count_pin),
        .ovf_irq_ack               (ovf_irq_ack),
        .cap_irq_ack               (cap_irq_ack),
        .ovf_irq                   (ovf_irq),
        .cap_irq                   (cap_irq),
        .count_at_top              (count_at_top),
        .count_at_bottom           (count_at_bottom)
    );

    tmc_host u_h (
        .clk         (clk),
        .bus_rdata   (bus_rdata),
        .bus_req     (bus_req),
        .ovf_irq_ack (ovf_irq_ack),
        .cap_irq_ack (cap_irq_ack)
    );

    always #50 clk = ~clk;

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Waits a bounded time for the capture request
    task automatic wirq(output int k);
        k = 0;
        while (cap_irq !== 1'b1 && k < 40)
        begin
            @(negedge clk);
            k++;
        end
    endtask

    task automatic meas(input logic lvl, output int k);
        @(negedge clk);
        capture_pin = lvl;
        wirq(k);
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            finish_test();
        end
    end

    initial
    begin
        clk = 1'b0;
        arst_n = 1'b0;
        capture_pin = 1'b0;
        comparator_output = 1'b0;
        comparator_capture_select = 1'b0;
        external_count_pin = 1'b0;
        errors = 0;
        total_checks = 0;
        cyc = 0;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        chk("bottom", 16'h1, 16'(count_at_bottom));
        chk("top", 16'h0, 16'(count_at_top));
        u_h.wr16(tmc_pkg::REG_CNT_HI, 16'h01ff);
        u_h.rd16(tmc_pkg::REG_CNT_LO, v);
        chk("count", 16'h01ff, v);
        repeat (20) @(negedge clk);
        u_h.rd16(tmc_pkg::REG_CNT_LO, v);
        chk("stopped", 16'h01ff, v);
        u_h.wr(tmc_pkg::REG_CNT_HI, 8'h5a);
        u_h.rd(tmc_pkg::REG_CAP_HI, b);
        chk("temp", 16'h005a, 16'(b));
        u_h.rd(4'hc, b);
        chk("unmapped", 16'h0, 16'(b));
        u_h.wr16(tmc_pkg::REG_CMPA_HI, 16'h1122);
        u_h.wr(tmc_pkg::REG_CNT_HI, 8'h99);
        u_h.rd(tmc_pkg::REG_CMPA_HI, b);
        chk("cmp_hi", 16'h0011, 16'(b));
        u_h.wr(tmc_pkg::REG_CMPB_LO, 8'h01);
        u_h.wr(tmc_pkg::REG_CMPA_LO, 8'h02);
        u_h.rd(tmc_pkg::REG_CMPB_HI, b);
        chk("reuse_b", 16'h0099, 16'(b));
        u_h.rd(tmc_pkg::REG_CMPA_HI, b);
        chk("reuse_a", 16'h0099, 16'(b));
        u_h.wr16(tmc_pkg::REG_CNT_HI, 16'hfffe);
        u_h.wr(tmc_pkg::REG_CTRL_B, 8'h01);
        u_h.wr(tmc_pkg::REG_CTRL_B, 8'h00);
        u_h.rd(tmc_pkg::REG_FLAGS, b);
        chk("ovf_flag", 16'h1, 16'(b & 8'h01));
        chk("bottom_wrap", 16'h1, 16'(count_at_bottom));
        u_h.wr(tmc_pkg::REG_MASK, 8'h01);
        repeat (3) @(negedge clk);
        chk("ovf_irq", 16'h1, 16'(ovf_irq));
        u_h.ack(1'b0);
        u_h.rd(tmc_pkg::REG_FLAGS, b);
        chk("ovf_ack", 16'h0, 16'(b & 8'h01));
        u_h.wr16(tmc_pkg::REG_CNT_HI, 16'h4321);
        u_h.wr(tmc_pkg::REG_MASK, 8'h02);
        u_h.wr(tmc_pkg::REG_CTRL_B, 8'h40);
        meas(1'b1, n0);
        chk("cap_irq", 16'h1, 16'(cap_irq));
        u_h.rd16(tmc_pkg::REG_CAP_LO, v);
        chk("capture", 16'h4321, v);
        u_h.rd(tmc_pkg::REG_FLAGS, b);
        chk("cap_flag", 16'h2, 16'(b & 8'h02));
        u_h.ack(1'b1);
        u_h.wr(tmc_pkg::REG_CTRL_B, 8'h00);
        meas(1'b0, n);
        chk("fall_edge", 16'h1, 16'(cap_irq));
        u_h.clr_cap();
        u_h.wr(tmc_pkg::REG_CTRL_B, 8'hc0);
        meas(1'b1, n);
        chk("filter_delay", 16'(n0 + 4), 16'(n));
        u_h.clr_cap();
        @(negedge clk);
        capture_pin = 1'b0;
        repeat (10) @(negedge clk);
        capture_pin = 1'b1;
        repeat (3) @(negedge clk);
        capture_pin = 1'b0;
        repeat (30) @(negedge clk);
        chk("glitch", 16'h0, 16'(cap_irq));
        comparator_capture_select = 1'b1;
        u_h.clr_cap();
        u_h.wr16(tmc_pkg::REG_CNT_HI, 16'h0777);
        meas(1'b1, n);
        chk("pin_ignored", 16'h0, 16'(cap_irq));
        @(negedge clk);
        comparator_output = 1'b1;
        wirq(n);
        chk("cmp_source", 16'h1, 16'(cap_irq));
        u_h.rd16(tmc_pkg::REG_CAP_LO, v);
        chk("cmp_capture", 16'h0777, v);
        u_h.clr_cap();
        u_h.wr16(tmc_pkg::REG_CAP_HI, 16'habcd);
        u_h.rd16(tmc_pkg::REG_CAP_LO, v);
        chk("cap_locked", 16'h0777, v);
        u_h.wr(tmc_pkg::REG_CTRL_B, 8'h18);
        u_h.wr16(tmc_pkg::REG_CAP_HI, 16'habcd);
        u_h.rd16(tmc_pkg::REG_CAP_LO, v);
        chk("cap_top", 16'habcd, v);
        u_h.wr16(tmc_pkg::REG_CNT_HI, 16'habcd);
        chk("at_top", 16'h1, 16'(count_at_top));
        chk("off_bottom", 16'h0, 16'(count_at_bottom));
        @(negedge clk);
        comparator_output = 1'b0;
        wirq(n);
        chk("mode_block", 16'h0, 16'(cap_irq));
        u_h.wr(tmc_pkg::REG_CTRL_B, 8'h01);
        u_h.wr16(tmc_pkg::REG_CNT_HI, 16'h1234);
        u_h.wr(tmc_pkg::REG_CTRL_B, 8'h00);
        u_h.rd16(tmc_pkg::REG_CNT_LO, v);
        chk("run_write", 16'h1237, v);
        finish_test();
    end
endmodule
`default_nettype wire
